/* core/psp_pkg.sv */
// shared constants of the paged serial register port and its host
package psp_pkg;
  // device side: page register window and address phase lengths
  localparam logic [4:0]  PAGE_WIN_1B = 5'h1F;      // offsets 0x7C..0x7F
  localparam logic [12:0] PAGE_WIN_2B = 13'h1FFF;   // offsets 0x7FFD..0x7FFF
  localparam logic [31:0] PAGE_RST    = 32'h0000_0000;
  localparam logic [3:0]  LAST_1B     = 4'h7;       // last address bit, 1-byte mode
  localparam logic [3:0]  LAST_2B     = 4'hF;       // last address bit, 2-byte mode
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  // host register offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_TX      = 8'h04;
  localparam logic [7:0]  REG_STAT    = 8'h08;
  localparam logic [7:0]  REG_RX      = 8'h0C;
  localparam logic [7:0]  REG_CFG     = 8'h10;
  // host register fields
  localparam int CTRL_GO    = 0;
  localparam int CTRL_TURN  = 1;
  localparam int CTRL_END   = 2;
  localparam int CFG_3W     = 0;
  localparam int CFG_FALL   = 1;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_CS    = 1;
  localparam logic [1:0] CFG_RST = 2'h0;
endpackage : psp_pkg

/* core/psp_link_if.sv */
// link wires between the serial host and the register port device
interface psp_link_if;
  logic sclk;
  logic cs_n;
  logic serial_data_input_pin;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic sdio;

  // shared data pin with a pull-up when neither end drives it
  assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);

  modport dev (input sclk, input cs_n, input serial_data_input_pin, input sdio,
               output dev_sdio_o, output dev_sdio_oe);
  modport host (output sclk, output cs_n, output serial_data_input_pin, output host_sdio_o,
                output host_sdio_oe, input sdio);
endinterface : psp_link_if

/* core/psp_device.sv */
// serial register port device: paged addressing, bursts, write events to hclk
// Functional notes
// - host keeps multi-byte register in one burst
// - host burst never passes page end
// - pointer advances one per data byte
// - command msb zero means write data
// - command msb one means read data
// - 1-byte write: page at 0x7C, then 0x64
// - 1-byte read: page at 0x7C, then 0xA4
// - 2-byte mode: page at 0x7FFD, two address bytes
// - optional half-period delay of read data
// - chip select high releases data pin
// - 1-byte address: 9 page bits, 7 bits
// - 2-byte address: 1 page bit, 15 bits
// - 4-wire default, 3-wire shared data pin
// - selectable sampling edge of sclk
module psp_device #(
  parameter int MEM_AW = 6
) (
  // link
  psp_link_if.dev link,
  // system clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // static configuration, change only while chip select is high
  input  wire logic        cfg_two_byte,
  input  wire logic        cfg_three_wire,
  input  wire logic        cfg_sample_fall,
  input  wire logic        cfg_read_delay,
  // register write events in the hclk domain
  output logic             wr_valid,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data
);

  typedef enum logic {PSP_ADDR, PSP_DATA} psp_dev_state_t;

  psp_dev_state_t state_q;
  logic           fall_s1_q, fall_s2_q;
  logic [2:0]     cfg_s1_q, cfg_s2_q;
  logic           two, tw, dly;
  logic           sclk_i, frame_rst, sin;
  logic [3:0]     cnt_q;
  logic [15:0]    sh_q;
  logic [15:0]    cmd;
  logic [14:0]    off_q, off_inc, cmd_off, rd_off;
  logic           rd_q, oe_q, addr_last, byte_end, cmd_rd;
  logic [7:0]     tx_q, byte_in, rd_val;
  logic           dly_o_q, dly_oe_q;
  logic [31:0]    page_q;
  logic [7:0]     mem_q [2**MEM_AW];
  logic [15:0]    ev_addr_q;
  logic [7:0]     ev_data_q;
  logic           ev_tgl_q;
  logic           tgl_s1_q, tgl_s2_q, tgl_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // page register window, same byte index in both modes
  function automatic logic pg_hit(input logic [14:0] o, input logic two_b);
    pg_hit = two_b ? (o[14:2] == psp_pkg::PAGE_WIN_2B && o[1:0] != 2'h0)
                   : (o[6:2] == psp_pkg::PAGE_WIN_1B);
  endfunction

  // full register address from page and offset
  function automatic logic [15:0] full_addr(input logic [14:0] o, input logic two_b,
                                            input logic [31:0] pg);
    full_addr = two_b ? {pg[15], o} : {pg[15:7], o[6:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clocking and configuration

  // edge select synchronised on the raw link clock, it then steers that clock
  always_ff @(posedge link.sclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_s1_q <= 1'b0;
      fall_s2_q <= 1'b0;
    end else begin
      fall_s1_q <= cfg_sample_fall;
      fall_s2_q <= fall_s1_q;
    end
  end

  assign sclk_i    = link.sclk ^ fall_s2_q;
  assign frame_rst = link.cs_n | ~hresetn;

  // remaining options cross into the link domain through two flops
  always_ff @(posedge sclk_i or negedge hresetn) begin
    if (!hresetn) begin
      cfg_s1_q <= 3'h0;
      cfg_s2_q <= 3'h0;
    end else begin
      cfg_s1_q <= {cfg_read_delay, cfg_three_wire, cfg_two_byte};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign two = cfg_s2_q[0];
  assign tw  = cfg_s2_q[1];
  assign dly = cfg_s2_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // decode of the incoming stream

  // 3-wire takes input from the shared pin
  assign sin       = tw ? link.sdio : link.serial_data_input_pin;
  assign cmd       = {sh_q[14:0], sin};
  assign byte_in   = cmd[7:0];
  assign addr_last = (state_q == PSP_ADDR) && (cnt_q == (two ? psp_pkg::LAST_2B : psp_pkg::LAST_1B));
  assign byte_end  = (state_q == PSP_DATA) && (cnt_q[2:0] == psp_pkg::LAST_BIT);
  assign cmd_rd    = two ? cmd[15] : cmd[7];
  assign cmd_off   = two ? cmd[14:0] : {8'h00, cmd[6:0]};
  // offset wraps inside the addressable field; the host stops at page end
  assign off_inc   = two ? 15'(off_q + 15'h0001) : {8'h00, 7'(off_q[6:0] + 7'h01)};
  assign rd_off    = addr_last ? cmd_off : off_inc;

  // read byte for the next launch, page register bytes overlay the memory
  always_comb begin
    logic [15:0] a;
    a = full_addr(rd_off, two, page_q);
    if (pg_hit(rd_off, two)) begin
      rd_val = page_q[8*rd_off[1:0] +: 8];
    end else begin
      rd_val = mem_q[a[MEM_AW-1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencing, cleared whenever chip select is high

  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      state_q <= PSP_ADDR;
      cnt_q   <= 4'h0;
      sh_q    <= 16'h0000;
      off_q   <= 15'h0000;
      rd_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      sh_q <= cmd;
      case (state_q)
        PSP_ADDR: begin
          if (addr_last) begin
            state_q <= PSP_DATA;
            cnt_q   <= 4'h0;
            off_q   <= cmd_off;
            rd_q    <= cmd_rd;
            oe_q    <= cmd_rd;
          end else begin
            cnt_q <= 4'(cnt_q + 4'h1);
          end
        end
        PSP_DATA: begin
          cnt_q <= {1'b0, 3'(cnt_q[2:0] + 3'h1)};
          if (byte_end) begin
            off_q <= off_inc;
          end
        end
        default: begin
          state_q <= PSP_ADDR;
        end
      endcase
    end
  end

  // read shifter: loaded at the last bit of a byte, launched msb first
  always_ff @(posedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      tx_q <= 8'h00;
    end else if (addr_last || (byte_end && rd_q)) begin
      tx_q <= rd_val;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // optional half-period delay moves the launch to the opposite edge
  always_ff @(negedge sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      dly_o_q  <= 1'b0;
      dly_oe_q <= 1'b0;
    end else begin
      dly_o_q  <= tx_q[7];
      dly_oe_q <= oe_q;
    end
  end

  assign link.dev_sdio_o  = dly ? dly_o_q : tx_q[7];
  assign link.dev_sdio_oe = dly ? dly_oe_q : oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // register storage and page register

  always_ff @(posedge sclk_i or negedge hresetn) begin
    if (!hresetn) begin
      page_q <= psp_pkg::PAGE_RST;
      for (int i = 0; i < 2**MEM_AW; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (!link.cs_n && byte_end && !rd_q) begin
      if (pg_hit(off_q, two)) begin
        page_q[8*off_q[1:0] +: 8] <= byte_in;
      end else begin
        mem_q[MEM_AW'(full_addr(off_q, two, page_q))] <= byte_in;
      end
    end
  end

  // write event held stable for the hclk side, one toggle per byte written to memory
  always_ff @(posedge sclk_i or negedge hresetn) begin
    if (!hresetn) begin
      ev_addr_q <= 16'h0000;
      ev_data_q <= 8'h00;
      ev_tgl_q  <= 1'b0;
    end else if (!link.cs_n && byte_end && !rd_q && !pg_hit(off_q, two)) begin
      ev_addr_q <= full_addr(off_q, two, page_q);
      ev_data_q <= byte_in;
      ev_tgl_q  <= ~ev_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hclk side of the write event

  // a byte lasts eight link clocks, so the held words are stable when sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr  <= 16'h0000;
      wr_data  <= 8'h00;
    end else begin
      tgl_s1_q <= ev_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      wr_valid <= tgl_s2_q ^ tgl_s3_q;
      if (tgl_s2_q ^ tgl_s3_q) begin
        wr_addr <= ev_addr_q;
        wr_data <= ev_data_q;
      end
    end
  end

endmodule // psp_device

/* core/psp_host.sv */
// serial host: AHB-Lite register slave that sends bytes over the link
module psp_host #(
  parameter int HALF = 4
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // link
  psp_link_if.host         link
);

  typedef enum logic [2:0] {PSH_IDLE, PSH_SETUP, PSH_LOW, PSH_HIGH, PSH_TAIL} psp_host_state_t;

  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  psp_host_state_t state_q;
  logic [7:0]      a_addr_q;
  logic            a_wr_q;
  logic [1:0]      cfg_q;
  logic [7:0]      txr_q, rx_q, sh_q;
  logic            go_q, turn_q, end_q, cs_n_q, sclk_q;
  logic            sdi_q, sdio_o_q, sdio_oe_q;
  logic [7:0]      tm_q;
  logic [2:0]      bi_q;
  logic            sd_s1_q, sd_s2_q;
  logic            busy;

  assign busy = (state_q != PSH_IDLE) || go_q;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  // address phase latch and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_addr_q  <= 8'h00;
      a_wr_q    <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      a_wr_q    <= hready && hsel && htrans[1] && hwrite;
      a_addr_q  <= haddr[7:0];
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          psp_pkg::REG_TX:   hrdata <= {24'h0, txr_q};
          psp_pkg::REG_STAT: hrdata <= {30'h0, !cs_n_q, busy};
          psp_pkg::REG_RX:   hrdata <= {24'h0, rx_q};
          psp_pkg::REG_CFG:  hrdata <= {30'h0, cfg_q};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // data phase writes; a start while busy is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q  <= psp_pkg::CFG_RST;
      txr_q  <= 8'h00;
      go_q   <= 1'b0;
      turn_q <= 1'b0;
      end_q  <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (a_wr_q) begin
        if (a_addr_q == psp_pkg::REG_TX) begin
          txr_q <= hwdata[7:0];
        end
        if (a_addr_q == psp_pkg::REG_CFG && state_q == PSH_IDLE && cs_n_q) begin
          cfg_q <= hwdata[1:0];
        end
        if (a_addr_q == psp_pkg::REG_CTRL && hwdata[psp_pkg::CTRL_GO] && !busy) begin
          go_q   <= 1'b1;
          turn_q <= hwdata[psp_pkg::CTRL_TURN];
          end_q  <= hwdata[psp_pkg::CTRL_END];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side

  // returning data passes two flops before it is sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sd_s1_q <= 1'b1;
      sd_s2_q <= 1'b1;
    end else begin
      sd_s1_q <= link.sdio;
      sd_s2_q <= sd_s1_q;
    end
  end

  // byte engine: idle level, drive bit, active edge, back to idle level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= PSH_IDLE;
      tm_q      <= 8'h00;
      bi_q      <= 3'h0;
      sh_q      <= 8'h00;
      rx_q      <= 8'h00;
      cs_n_q    <= 1'b1;
      sclk_q    <= 1'b0;
      sdi_q     <= 1'b0;
      sdio_o_q  <= 1'b0;
      sdio_oe_q <= 1'b0;
    end else begin
      case (state_q)
        PSH_IDLE: begin
          sclk_q <= cfg_q[psp_pkg::CFG_FALL];
          if (go_q) begin
            sh_q   <= txr_q;
            bi_q   <= 3'h0;
            tm_q   <= HALF_M1;
            cs_n_q <= 1'b0;
            state_q <= cs_n_q ? PSH_SETUP : PSH_LOW;
            if (!cs_n_q) begin
              sdi_q     <= txr_q[7];
              sdio_o_q  <= txr_q[7];
              sdio_oe_q <= cfg_q[psp_pkg::CFG_3W] && !turn_q;
            end
          end
        end
        PSH_SETUP: begin
          sdi_q     <= sh_q[7];
          sdio_o_q  <= sh_q[7];
          sdio_oe_q <= cfg_q[psp_pkg::CFG_3W] && !turn_q;
          if (tm_q == 8'h00) begin
            tm_q    <= HALF_M1;
            state_q <= PSH_LOW;
          end else begin
            tm_q <= 8'(tm_q - 8'h01);
          end
        end
        PSH_LOW: begin
          if (tm_q == 8'h00) begin
            rx_q    <= {rx_q[6:0], sd_s2_q};
            sclk_q  <= !cfg_q[psp_pkg::CFG_FALL];
            tm_q    <= HALF_M1;
            state_q <= PSH_HIGH;
          end else begin
            tm_q <= 8'(tm_q - 8'h01);
          end
        end
        PSH_HIGH: begin
          if (tm_q == 8'h00) begin
            sclk_q  <= cfg_q[psp_pkg::CFG_FALL];
            tm_q    <= HALF_M1;
            bi_q    <= 3'(bi_q + 3'h1);
            sh_q    <= {sh_q[6:0], 1'b0};
            sdi_q   <= sh_q[6];
            sdio_o_q <= sh_q[6];
            state_q <= (bi_q == psp_pkg::LAST_BIT) ? PSH_TAIL : PSH_LOW;
          end else begin
            tm_q <= 8'(tm_q - 8'h01);
          end
        end
        PSH_TAIL: begin
          // the idle half lets a delayed read bit finish before release
          if (tm_q == 8'h00) begin
            state_q   <= PSH_IDLE;
            sdio_oe_q <= 1'b0;
            cs_n_q    <= end_q;
          end else begin
            tm_q <= 8'(tm_q - 8'h01);
          end
        end
        default: begin
          state_q <= PSH_IDLE;
        end
      endcase
    end
  end

  assign link.sclk                  = sclk_q;
  assign link.cs_n                  = cs_n_q;
  assign link.serial_data_input_pin = sdi_q;
  assign link.host_sdio_o           = sdio_o_q;
  assign link.host_sdio_oe          = sdio_oe_q;

endmodule // psp_host

/* verif/psp_link_asserts.sv */
// checker of the link wires between the serial host and the register port
module psp_link_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic host_sdio_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // rising sclk edges seen in a frame; only whole bytes may end a frame
  logic [2:0] edge_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_q <= 3'h0;
    end else if (cs_n) begin
      edge_q <= 3'h0;
    end else if ($rose(sclk)) begin
      edge_q <= edge_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link rules
  AST_CS_RELEASE: assert property (cs_n |-> !dev_sdio_oe)
    else $error("device drives data pin while deselected");
  AST_HOST_IDLE: assert property (cs_n && $past(cs_n) |-> !host_sdio_oe)
    else $error("host drives data pin outside a frame");
  AST_CS_SETUP: assert property ($fell(cs_n) |-> $stable(sclk) [*3])
    else $error("sclk moved during chip select setup");
  AST_CS_HOLD: assert property ($rose(cs_n) |-> $stable(sclk) [*2])
    else $error("sclk moved around chip select release");
  AST_SCLK_HALF: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("sclk half period too short");
  AST_LAUNCH: assert property (dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_o) |-> $changed(sclk))
    else $error("read data changed away from an sclk edge");
  AST_OE_TURN: assert property ($rose(dev_sdio_oe) |-> !cs_n && $changed(sclk))
    else $error("device took the data pin away from an sclk edge");
  AST_BYTE_FRAME: assert property ($rose(cs_n) |-> edge_q == 3'h0)
    else $error("frame ended on a partial byte");

  // main scenarios
  cover property ($rose(dev_sdio_oe));
  cover property ($rose(host_sdio_oe));
  cover property ($rose(cs_n) && $past(edge_q) == 3'h0);
endmodule // psp_link_asserts

/* verif/tb_paged_spi_register_port.sv */
// testbench: AHB-Lite host drives the register port device over the link
module tb_paged_spi_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        cfg_two_byte = 1'b0;
  logic        cfg_three_wire = 1'b0;
  logic        cfg_sample_fall = 1'b0;
  logic        cfg_read_delay = 1'b0;
  logic        wr_valid;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic [23:0] wr_q[$];
  logic [7:0]  mon_q = 8'h0;
  logic [7:0]  rx_q;
  logic [31:0] rd_q;
  logic [7:0]  v;
  int          n_mismatch = 0;
  int          checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, both ends, checker
  always #25 hclk = ~hclk;
  psp_link_if link ();
  psp_host i_psp_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link));
  psp_device i_psp_device (.link(link), .hclk(hclk), .hresetn(hresetn), .cfg_two_byte(cfg_two_byte),
    .cfg_three_wire(cfg_three_wire), .cfg_sample_fall(cfg_sample_fall), .cfg_read_delay(cfg_read_delay),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
  psp_link_asserts i_psp_link_asserts (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk), .cs_n(link.cs_n),
    .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe), .host_sdio_oe(link.host_sdio_oe));

  // wire monitor shifts the data line at each active edge, so the last byte sits in mon_q
  always @(link.sclk) begin
    if (link.cs_n === 1'b0 && link.sclk === ~cfg_sample_fall) begin
      mon_q <= {mon_q[6:0], cfg_three_wire ? link.sdio : link.serial_data_input_pin};
    end
  end
  // register write events of the device
  always @(posedge hclk) begin
    if (wr_valid === 1'b1) begin
      wr_q.push_back({wr_addr, wr_data});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask

  // one single AHB transfer; hready of the bus is the slave's hreadyout
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin n_mismatch++; summarize(); end
  endtask

  // one byte over the link; busy is polled under a bound
  task xfer(input logic [7:0] t, input logic tn, input logic en);
    int n;
    ahb(1'b1, psp_pkg::REG_TX, {24'h0, t}, rd_q);
    ahb(1'b1, psp_pkg::REG_CTRL, {29'h0, en, tn, 1'b1}, rd_q);
    @(posedge hclk);
    n = 0;
    do begin ahb(1'b0, psp_pkg::REG_STAT, 32'h0, rd_q); n++; end while (rd_q[0] !== 1'b0 && n < 200);
    if (n >= 200) begin n_mismatch++; summarize(); end
    ahb(1'b0, psp_pkg::REG_RX, 32'h0, rd_q);
    rx_q = rd_q[7:0];
    chk({24'h0, mon_q}, {24'h0, tn ? rx_q : t});
  endtask

  // a frame of n bytes, left aligned in b; a read frame turns the last byte in 3-wire
  task frame(input logic [39:0] b, input int n, input logic rd);
    int k;
    for (k = 0; k < n; k++) begin
      xfer(b[39-8*k -: 8], rd && k == n - 1 && cfg_three_wire, k == n - 1);
    end
    chk({30'h0, link.cs_n, link.sdio}, 32'h3);
    chk({31'h0, link.sclk}, {31'h0, cfg_sample_fall});
  endtask

  task expect_wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    for (n = 0; n < 60 && wr_q.size() == 0; n++) @(posedge hclk);
    if (wr_q.size() == 0) chk(32'hFFFFFFFF, {8'h0, a, d});
    else chk({8'h0, wr_q.pop_front()}, {8'h0, a, d});
  endtask

  // configuration of both ends while deselected, then one throw-away frame
  task setcfg(input logic b2, input logic tw, input logic fa, input logic dl);
    cfg_two_byte <= b2;
    cfg_three_wire <= tw;
    cfg_sample_fall <= fa;
    cfg_read_delay <= dl;
    ahb(1'b1, psp_pkg::REG_CFG, {30'h0, fa, tw}, rd_q);
    ahb(1'b0, psp_pkg::REG_CFG, 32'h0, rd_q);
    chk(rd_q, {30'h0, fa, tw});
    frame(40'h8000000000, 1, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, psp_pkg::REG_CFG, 32'h0, rd_q);
    chk(rd_q, 32'h0);
    ahb(1'b0, psp_pkg::REG_STAT, 32'h0, rd_q);
    chk(rd_q, 32'h0);
    ahb(1'b1, 8'h14, 32'hFF, rd_q);
    ahb(1'b0, 8'h14, 32'h0, rd_q);
    chk(rd_q, 32'h0);
    $display("test registers done");
    setcfg(1'b0, 1'b0, 1'b0, 1'b0);
    frame(40'h7C80CB1020, 5, 1'b0);
    frame(40'h6450000000, 2, 1'b0);
    expect_wr(16'hCBE4, 8'h50);
    frame(40'h6400000000, 1, 1'b0);
    frame(40'h6511220000, 3, 1'b0);
    expect_wr(16'hCBE5, 8'h11);
    expect_wr(16'hCBE6, 8'h22);
    $display("test one-byte write done");
    frame(40'h7C00C01020, 5, 1'b0);
    for (int i = 0; i < 8; i++) begin
      v = 8'h30 + 8'(i);
      setcfg(1'b0, i[0], i[1], i[2]);
      frame({8'h24, v, 24'h0}, 2, 1'b0);
      expect_wr(16'hC024, v);
      frame({8'hA4, 32'h0}, 2, 1'b1);
      chk({24'h0, rx_q}, {24'h0, v});
    end
    $display("test wiring modes done");
    setcfg(1'b1, 1'b0, 1'b0, 1'b0);
    frame(40'h7FFD801020, 5, 1'b0);
    frame(40'h4BE4500000, 3, 1'b0);
    expect_wr(16'hCBE4, 8'h50);
    frame(40'hC024000000, 3, 1'b1);
    chk({24'h0, rx_q}, 32'h50);
    chk(32'(wr_q.size()), 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test two-byte mode done");
    summarize();
  end
endmodule // tb_paged_spi_register_port
